// ---- rtl/ccdseq_defines.svh ----
// Timing counts and line geometry for the line clock sequencer
`ifndef CCDSEQ_DEFINES_SVH
`define CCDSEQ_DEFINES_SVH
`define CCDSEQ_FULL_PIXELS     12'h832
`define CCDSEQ_SUM_PIXELS      12'h419
`define CCDSEQ_OVERHEAD        12'h010
`define CCDSEQ_CNT_W           12
`define CCDSEQ_HALF_CYC        4'h4
`define CCDSEQ_STOP_CYC        8'h04
`define CCDSEQ_TGON_CYC        8'h20
`define CCDSEQ_TG1OFF_CYC      8'h10
`define CCDSEQ_TG2OFF_CYC      8'h04
`define CCDSEQ_RST_CYC         4'h1
`endif

// ---- rtl/ccdseq_pkg.sv ----
// Types of the line clock sequencer
package ccdseq_pkg;
   typedef enum logic [5:0] {
      CCDSEQ_IDLE   = 6'h01,
      CCDSEQ_STOP   = 6'h02,
      CCDSEQ_TGON   = 6'h04,
      CCDSEQ_TG1OFF = 6'h08,
      CCDSEQ_TG2OFF = 6'h10,
      CCDSEQ_READ   = 6'h20
   } ccdseq_state_t;
endpackage : ccdseq_pkg

// ---- rtl/ccdseq_sync.sv ----
// Two flip-flop synchroniser for one level
`timescale 1ns/10ps
module ccdseq_sync (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_q;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= 1'b0;
         o_q    <= 1'b0;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule : ccdseq_sync

// ---- rtl/ccdseq_ovg.sv ----
// One channel overflow gate: high from line transfer until exposure point
`timescale 1ns/10ps
`include "ccdseq_defines.svh"
module ccdseq_ovg (
   input  wire logic                    i_clk,
   input  wire logic                    i_rstn,
   input  wire logic                    i_set,
   input  wire logic                    i_shift_edge,
   input  wire logic [`CCDSEQ_CNT_W-1:0] i_pix,
   input  wire logic [`CCDSEQ_CNT_W-1:0] i_fall_at,
   output logic                         o_gate
);
   logic gate_d;
   always_comb begin
      gate_d = o_gate;
      if (i_set)
         gate_d = 1'b1;
      else if (i_shift_edge && i_pix >= i_fall_at)
         gate_d = 1'b0;
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn)
         o_gate <= 1'b0;
      else
         o_gate <= gate_d;
   end
endmodule : ccdseq_ovg

// ---- rtl/ccdseq_top.sv ----
// Line clock sequencer driving a three channel linear image sensor
`timescale 1ns/10ps
`include "ccdseq_defines.svh"
// Behaviour
// - Overflow gate high while inner gate off drains photocurrent entirely.
// - Overflow gate rises as inner gate falls, falls later in line.
// - Exposure runs from overflow fall to next inner gate fall.
// - Separate overflow gate outputs for red, green and blue.
// - Overflow gates rise on the inner transfer gate falling edge.
// - Overflow gates fall on a shift clock edge.
// - Both transfer gates stay off during integration and readout.
// - Shift stops with phase one high, phase two low before transfer.
// - With shifting stopped both transfer gates turn on.
// - Inner transfer gate turns off first, outer one afterwards.
// - Complementary shift clocking resumes after outer gate off.
// - Reset clock pulses before every output pixel.
// - Summing mode: summing clock 75% duty, half phase-two rate.
// - Full mode: summing clock equals phase two clock.
module ccdseq_top (
   input  wire logic                    i_clk,
   input  wire logic                    i_rstn,
   input  wire logic                    i_enable,
   input  wire logic                    i_sum_mode,
   input  wire logic [`CCDSEQ_CNT_W-1:0] i_exp_red,
   input  wire logic [`CCDSEQ_CNT_W-1:0] i_exp_green,
   input  wire logic [`CCDSEQ_CNT_W-1:0] i_exp_blue,
   output logic                         o_phase1,
   output logic                         o_phase2,
   output logic                         o_summing_gate_clock,
   output logic                         o_reset_clock,
   output logic                         o_inner_transfer_gate,
   output logic                         o_outer_transfer_gate,
   output logic                         o_red_overflow_gate,
   output logic                         o_green_overflow_gate,
   output logic                         o_blue_overflow_gate,
   output logic                         o_line_start
);
   localparam int W = `CCDSEQ_CNT_W;
   logic rst1_q, rstn_q;
   logic en_s, sum_s;
   ccdseq_pkg::ccdseq_state_t st_q, st_d;
   logic [7:0]   tmr_q, tmr_d;
   logic [3:0]   half_q, half_d;
   logic [W-1:0] pix_q, pix_d;
   logic         ph1_q, ph1_d;
   logic         sg_q, sg_d;
   logic         rc_q, rc_d;
   logic         tg1_q, tg1_d;
   logic         tg2_q, tg2_d;
   logic         ls_q, ls_d;
   logic         sum_q, sum_d;
   logic         ovg_set;
   logic         shift_edge;
   logic [W-1:0] line_len;
   logic [W-1:0] exp_r, exp_g, exp_b;
   logic [W-1:0] fall_r, fall_g, fall_b;
   logic [7:0]   tg2_hold_q, tg2_hold_d;

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst1_q <= 1'b0;
         rstn_q <= 1'b0;
      end else begin
         rst1_q <= 1'b1;
         rstn_q <= rst1_q;
      end
   end

   ccdseq_sync u_sync_en (
      .i_clk  (i_clk),
      .i_rstn (rstn_q),
      .i_d    (i_enable),
      .o_q    (en_s)
   );
   ccdseq_sync u_sync_sum (
      .i_clk  (i_clk),
      .i_rstn (rstn_q),
      .i_d    (i_sum_mode),
      .o_q    (sum_s)
   );

   // Shift cycles per line; a summed pixel takes two shift cycles
   assign line_len = sum_q ? 12'((`CCDSEQ_SUM_PIXELS + `CCDSEQ_OVERHEAD) << 1)
                           : `CCDSEQ_FULL_PIXELS + `CCDSEQ_OVERHEAD;
   // Exposure count saturates at line length
   assign exp_r = (i_exp_red   > line_len) ? line_len : i_exp_red;
   assign exp_g = (i_exp_green > line_len) ? line_len : i_exp_green;
   assign exp_b = (i_exp_blue  > line_len) ? line_len : i_exp_blue;
   // Gate falls so that exposure count remains until line end
   assign fall_r = line_len - exp_r;
   assign fall_g = line_len - exp_g;
   assign fall_b = line_len - exp_b;

   // Overflow rises with the inner transfer gate falling edge
   assign ovg_set = (st_q == ccdseq_pkg::CCDSEQ_TG1OFF) && ls_q;
   // Phase one falling edge is a shift clock edge
   assign shift_edge = (st_q == ccdseq_pkg::CCDSEQ_READ) && ph1_q &&
                       (half_q == `CCDSEQ_HALF_CYC - 4'h1);

   always_comb begin
      st_d   = st_q;
      tmr_d  = tmr_q;
      half_d = half_q;
      pix_d  = pix_q;
      ph1_d  = ph1_q;
      sg_d   = sg_q;
      rc_d   = 1'b0;
      tg1_d  = tg1_q;
      tg2_d  = tg2_q;
      ls_d   = 1'b0;
      sum_d  = sum_q;
      case (st_q)
         ccdseq_pkg::CCDSEQ_IDLE: begin
            ph1_d = 1'b1;
            sg_d  = 1'b0;
            tg1_d = 1'b0;
            tg2_d = 1'b0;
            if (en_s) begin
               sum_d = sum_s;
               tmr_d = `CCDSEQ_STOP_CYC;
               st_d  = ccdseq_pkg::CCDSEQ_STOP;
            end
         end
         ccdseq_pkg::CCDSEQ_STOP: begin
            ph1_d = 1'b1;
            sg_d  = 1'b0;
            tmr_d = tmr_q - 8'h01;
            if (tmr_q == 8'h01) begin
               tg1_d = 1'b1;
               tg2_d = 1'b1;
               tmr_d = `CCDSEQ_TGON_CYC;
               st_d  = ccdseq_pkg::CCDSEQ_TGON;
            end
         end
         ccdseq_pkg::CCDSEQ_TGON: begin
            tmr_d = tmr_q - 8'h01;
            if (tmr_q == 8'h01) begin
               tg1_d = 1'b0;
               ls_d  = 1'b1;
               tmr_d = `CCDSEQ_TG1OFF_CYC;
               st_d  = ccdseq_pkg::CCDSEQ_TG1OFF;
            end
         end
         ccdseq_pkg::CCDSEQ_TG1OFF: begin
            tmr_d = tmr_q - 8'h01;
            if (tmr_q == 8'h01) begin
               tg2_d = 1'b0;
               tmr_d = `CCDSEQ_TG2OFF_CYC;
               st_d  = ccdseq_pkg::CCDSEQ_TG2OFF;
            end
         end
         ccdseq_pkg::CCDSEQ_TG2OFF: begin
            tmr_d = tmr_q - 8'h01;
            if (tmr_q == 8'h01) begin
               half_d = 4'h0;
               pix_d  = '0;
               st_d   = ccdseq_pkg::CCDSEQ_READ;
            end
         end
         ccdseq_pkg::CCDSEQ_READ: begin
            half_d = half_q + 4'h1;
            if (half_q == `CCDSEQ_HALF_CYC - 4'h1) begin
               half_d = 4'h0;
               ph1_d  = ~ph1_q;
               if (ph1_q) begin
                  // Phase two rises: reset pulse precedes the next pixel
                  if (!sum_q || pix_q[0])
                     rc_d = 1'b1;
               end else begin
                  pix_d = pix_q + 1'b1;
                  if (pix_q + 1'b1 == line_len) begin
                     tmr_d = `CCDSEQ_STOP_CYC;
                     sum_d = sum_s;
                     st_d  = en_s ? ccdseq_pkg::CCDSEQ_STOP
                                  : ccdseq_pkg::CCDSEQ_IDLE;
                  end
               end
            end
            // Full: summing clock is phase two itself
            if (!sum_q)
               sg_d = ~ph1_d;
            // Summing: low only in the first half of each even pixel
            else if (half_q == `CCDSEQ_HALF_CYC - 4'h1)
               sg_d = !(!ph1_q && pix_q[0]);
         end
         default: st_d = ccdseq_pkg::CCDSEQ_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge rstn_q) begin
      if (!rstn_q) begin
         st_q   <= ccdseq_pkg::CCDSEQ_IDLE;
         tmr_q  <= 8'h00;
         half_q <= 4'h0;
         pix_q  <= '0;
         ph1_q  <= 1'b1;
         sg_q   <= 1'b0;
         rc_q   <= 1'b0;
         tg1_q  <= 1'b0;
         tg2_q  <= 1'b0;
         ls_q   <= 1'b0;
         sum_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         tmr_q  <= tmr_d;
         half_q <= half_d;
         pix_q  <= pix_d;
         ph1_q  <= ph1_d;
         sg_q   <= sg_d;
         rc_q   <= rc_d;
         tg1_q  <= tg1_d;
         tg2_q  <= tg2_d;
         ls_q   <= ls_d;
         sum_q  <= sum_d;
      end
   end

   // One gate per channel, common timing otherwise
   ccdseq_ovg u_ovg_r (
      .i_clk        (i_clk),
      .i_rstn       (rstn_q),
      .i_set        (ovg_set),
      .i_shift_edge (shift_edge),
      .i_pix        (pix_q),
      .i_fall_at    (fall_r),
      .o_gate       (o_red_overflow_gate)
   );
   ccdseq_ovg u_ovg_g (
      .i_clk        (i_clk),
      .i_rstn       (rstn_q),
      .i_set        (ovg_set),
      .i_shift_edge (shift_edge),
      .i_pix        (pix_q),
      .i_fall_at    (fall_g),
      .o_gate       (o_green_overflow_gate)
   );
   ccdseq_ovg u_ovg_b (
      .i_clk        (i_clk),
      .i_rstn       (rstn_q),
      .i_set        (ovg_set),
      .i_shift_edge (shift_edge),
      .i_pix        (pix_q),
      .i_fall_at    (fall_b),
      .o_gate       (o_blue_overflow_gate)
   );

   // Sensor-side behaviour relied on
   assign o_phase1              = ph1_q;
   assign o_phase2              = ~ph1_q;
   assign o_summing_gate_clock  = sg_q;
   assign o_reset_clock         = rc_q;
   assign o_inner_transfer_gate = tg1_q;
   assign o_outer_transfer_gate = tg2_q;
   assign o_line_start          = ls_q;

   // Cycles the outer gate has stayed on since the inner gate fell
   always_comb begin
      tg2_hold_d = 8'h00;
      if (!tg1_q && tg2_q)
         tg2_hold_d = tg2_hold_q + 8'h01;
   end
   always_ff @(posedge i_clk or negedge rstn_q) begin
      if (!rstn_q)
         tg2_hold_q <= 8'h00;
      else
         tg2_hold_q <= tg2_hold_d;
   end

   AST_STOP_BEFORE_TG: assert property (@(posedge i_clk)
      disable iff (!rstn_q) $rose(tg1_q) |-> ph1_q && !sg_q)
      else $error("shift not stopped");
   AST_BOTH_ON: assert property (@(posedge i_clk)
      disable iff (!rstn_q) $rose(tg1_q) |-> $rose(tg2_q))
      else $error("gates not together");
   sequence s_tg1_off;
      $fell(tg1_q) && tg2_q;
   endsequence
   AST_TG_ORDER: assert property (@(posedge i_clk)
      disable iff (!rstn_q) s_tg1_off |-> ##16 $fell(tg2_q))
      else $error("gate order");
   AST_TG_HOLD: assert property (@(posedge i_clk)
      disable iff (!rstn_q)
      $fell(tg2_q) |-> !tg1_q && tg2_hold_q == `CCDSEQ_TG1OFF_CYC)
      else $error("outer gate released early");
   AST_OVG_RISE: assert property (@(posedge i_clk)
      disable iff (!rstn_q) $fell(tg1_q) |-> ##1 o_red_overflow_gate &&
      o_green_overflow_gate && o_blue_overflow_gate)
      else $error("ovg rise");
   AST_TG_QUIET: assert property (@(posedge i_clk)
      disable iff (!rstn_q)
      st_q == ccdseq_pkg::CCDSEQ_READ |-> !tg1_q && !tg2_q)
      else $error("gate on in readout");
   AST_FULL_SG: assert property (@(posedge i_clk)
      disable iff (!rstn_q) st_q == ccdseq_pkg::CCDSEQ_READ && !sum_q ##1
      st_q == ccdseq_pkg::CCDSEQ_READ |-> sg_q == ~ph1_q)
      else $error("summing clock not phase two");
   AST_SUM_SG_FALL: assert property (@(posedge i_clk)
      disable iff (!rstn_q) sum_q && $fell(sg_q) |-> $rose(ph1_q))
      else $error("summing clock fall off phase two fall");
   AST_RST_PULSE: assert property (@(posedge i_clk)
      disable iff (!rstn_q) rc_q |=> !rc_q)
      else $error("reset pulse too long");
   AST_RESUME: assert property (@(posedge i_clk)
      disable iff (!rstn_q) $fell(tg2_q) |-> ##[5:12] !ph1_q)
      else $error("no resume");
   AST_OVG_FALL: assert property (@(posedge i_clk)
      disable iff (!rstn_q)
      $fell(o_blue_overflow_gate) |-> !ph1_q && $past(ph1_q))
      else $error("ovg fall off edge");
endmodule : ccdseq_top

// ---- sim/ccdseq_sensor_model.sv ----
// Behavioural model of the three channel linear sensor
`timescale 1ns/10ps
module ccdseq_sensor_model (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ph1,
   input  wire logic        i_ph2,
   input  wire logic        i_sum,
   input  wire logic        i_rst,
   input  wire logic        i_tg1,
   input  wire logic        i_tg2,
   input  wire logic [2:0]  i_ovg,
   output logic [2:0][15:0] o_exp,
   output logic [15:0]      o_pkt,
   output logic [15:0]      o_ph2,
   output logic [15:0]      o_rcnt,
   output logic [15:0]      o_hi,
   output logic [15:0]      o_lo,
   output logic [15:0]      o_fault
);
   logic [2:0][15:0] cnt_q;
   logic [15:0]      pkt_q, ph2_q, rst_q, run_q;
   logic [2:0]       ovg_p;
   logic             ph1_p, ph2_p, sum_p, tg1_p, tg2_p, seen_q;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= '0; pkt_q <= '0; ph2_q <= '0; rst_q <= '0;
         run_q <= '0; ovg_p <= '0; seen_q <= 1'b0;
         {ph1_p, ph2_p, sum_p, tg1_p, tg2_p} <= 5'h10;
         o_exp <= '0; o_pkt <= '0; o_ph2 <= '0; o_rcnt <= '0;
         o_hi <= '0; o_lo <= '0; o_fault <= '0;
      end else begin
         {ph1_p, ph2_p, sum_p, tg1_p, tg2_p} <=
            {i_ph1, i_ph2, i_sum, i_tg1, i_tg2};
         ovg_p <= i_ovg;
         for (int c = 0; c < 3; c++) begin
            cnt_q[c] <= i_ovg[c] ? 16'h0000 : cnt_q[c] + 16'h0001;
            if (i_ovg[c] && !ovg_p[c] && !i_tg2)
               o_fault <= o_fault + 16'h0001;
            if (!i_ovg[c] && ovg_p[c] && !(ph1_p && !i_ph1))
               o_fault <= o_fault + 16'h0001;
         end
         if (ph2_p && !i_ph2)
            ph2_q <= ph2_q + 16'h0001;
         run_q <= (i_sum != sum_p) ? 16'h0001 : run_q + 16'h0001;
         if (!sum_p && i_sum)
            o_lo <= run_q;
         if (sum_p && !i_sum) begin
            pkt_q <= pkt_q + 16'h0001;
            o_hi <= run_q;
            seen_q <= 1'b0;
            if (!seen_q)
               o_fault <= o_fault + 16'h0001;
         end
         if (i_rst) begin
            rst_q <= rst_q + 16'h0001;
            seen_q <= 1'b1;
         end
         if ((i_tg1 || i_tg2) && !(i_ph1 && !i_ph2))
            o_fault <= o_fault + 16'h0001;
         if ((tg2_p && !i_tg2 && i_tg1) || (i_tg1 && !i_tg2 && !tg1_p))
            o_fault <= o_fault + 16'h0001;
         if (tg1_p && !i_tg1) begin
            o_exp <= cnt_q; o_pkt <= pkt_q; o_ph2 <= ph2_q;
            o_rcnt <= rst_q; pkt_q <= '0; ph2_q <= '0; rst_q <= '0;
         end
      end
   end
endmodule : ccdseq_sensor_model

// ---- sim/ccd_line_clock_sequencer_tb_top.sv ----
// Self-checking bench of the line clock sequencer with a sensor model
`timescale 1ns/10ps
`include "ccdseq_defines.svh"
module ccd_line_clock_sequencer_tb_top;
   localparam int PIX  = 2 * `CCDSEQ_HALF_CYC;
   localparam int LINE = `CCDSEQ_FULL_PIXELS + `CCDSEQ_OVERHEAD;
   localparam int LSUM = 2 * (`CCDSEQ_SUM_PIXELS + `CCDSEQ_OVERHEAD);
   logic             clk = 1'b0, rstn = 1'b0, enable = 1'b0, sum_mode = 1'b0;
   logic [11:0]      exp_r = 12'h064, exp_g = 12'h0C8, exp_b = 12'hFFF;
   logic             ph1, ph2, sg, rc, tg1, tg2, ls;
   logic [2:0]       ovg;
   logic [2:0][15:0] m_exp;
   logic [15:0]      m_pkt, m_ph2, m_rc, m_hi, m_lo, m_flt, mism;
   logic             chk16 = 1'b0;
   int               error_cnt = 0, n_checks = 0;
   always #5 clk = ~clk;
   ccdseq_top u_dut (.i_clk(clk), .i_rstn(rstn), .i_enable(enable),
      .i_sum_mode(sum_mode), .i_exp_red(exp_r), .i_exp_green(exp_g),
      .i_exp_blue(exp_b), .o_phase1(ph1), .o_phase2(ph2),
      .o_summing_gate_clock(sg), .o_reset_clock(rc),
      .o_inner_transfer_gate(tg1), .o_outer_transfer_gate(tg2),
      .o_red_overflow_gate(ovg[0]), .o_green_overflow_gate(ovg[1]),
      .o_blue_overflow_gate(ovg[2]), .o_line_start(ls));
   ccdseq_sensor_model u_model (.i_clk(clk), .i_rstn(rstn), .i_ph1(ph1),
      .i_ph2(ph2), .i_sum(sg), .i_rst(rc), .i_tg1(tg1), .i_tg2(tg2),
      .i_ovg(ovg), .o_exp(m_exp), .o_pkt(m_pkt), .o_ph2(m_ph2),
      .o_rcnt(m_rc), .o_hi(m_hi), .o_lo(m_lo), .o_fault(m_flt));
   initial mism = 16'h0000;
   always @(negedge clk) begin
      if (chk16 && !tg1 && sg !== ph2)
         mism = mism + 16'h0001;
   end
   task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic wait_ls();
      int i;
      for (i = 0; i < 20000 && ls !== 1'b1; i++)
         @(negedge clk);
      if (i == 20000) begin
         error_cnt++;
         end_sim();
      end
      repeat (3) @(negedge clk);
   endtask : wait_ls
   task automatic t_full();
      @(posedge clk) enable <= 1'b1;
      wait_ls();
      chk16 = 1'b1;
      wait_ls();
      chk16 = 1'b0;
      cmp("exp_gr", 16'(100 * PIX), m_exp[1] - m_exp[0]);
      cmp("exp_bg", 16'((LINE - 200) * PIX), m_exp[2] - m_exp[1]);
      cmp("ph2_full", 16'(LINE), m_ph2);
      cmp("pkt_full", 16'(LINE), m_pkt);
      cmp("rst_full", 16'(LINE), m_rc);
      cmp("sg_eq_ph2", 16'h0000, mism);
      cmp("fault_full", 16'h0000, m_flt);
   endtask : t_full
   task automatic t_sum();
      @(posedge clk) sum_mode <= 1'b1;
      wait_ls();
      wait_ls();
      cmp("ph2_sum", 16'(LSUM), m_ph2);
      cmp("pkt_sum", 16'(LSUM / 2), m_pkt);
      cmp("rst_sum", 16'(LSUM / 2), m_rc);
      cmp("sg_high", 16'(3 * PIX / 2), m_hi);
      cmp("sg_low", 16'(PIX / 2), m_lo);
      cmp("fault_sum", 16'h0000, m_flt);
   endtask : t_sum
   task automatic t_stop();
      int          i;
      logic [15:0] n, k;
      n = 16'h0000;
      k = 16'h0000;
      @(posedge clk) enable <= 1'b0;
      // The running line finishes, then no further line may start
      for (i = 0; i < LSUM * PIX + 300; i++) begin
         @(negedge clk);
         if (ls === 1'b1)
            n = n + 16'h0001;
         if (i >= LSUM * PIX + 100 && ph1 !== 1'b1)
            k = k + 16'h0001;
      end
      cmp("ls_after_stop", 16'h0000, n);
      cmp("idle_ph1_low", 16'h0000, k);
      cmp("idle_ph1", 16'h0001, {15'h0000, ph1});
      cmp("idle_tg", 16'h0000, {14'h0000, tg1, tg2});
      cmp("fault_end", 16'h0000, m_flt);
   endtask : t_stop
   task automatic end_sim();
      if (error_cnt == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (95000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      t_full();
      t_sum();
      t_stop();
      end_sim();
   end
endmodule : ccd_line_clock_sequencer_tb_top
